// [common/sfc_pkg.sv]
package sfc_pkg;
	// Byte addresses of the register map
	localparam logic [13:0] SCFG_OFS  = 14'h2004;
	localparam logic [13:0] QCFG_OFS  = 14'h2008;
	localparam logic [13:0] CRC_OFS   = 14'h2060;
	localparam logic [13:0] TMO_OFS   = 14'h2068;
	localparam logic [13:0] RQOUT_OFS = 14'h206c;
	localparam logic [13:0] CQIN_OFS  = 14'h2070;
	localparam logic [13:0] LOCK_OFS  = 14'h2118;
	localparam logic [13:0] TRIG_OFS  = 14'h211c;
	// Values after reset
	localparam logic [15:0] QCFG_RST  = 16'h1010;
	localparam logic [15:0] SCFG_RST  = 16'h0002;
	localparam logic [7:0]  CRC_RST   = 8'h01;
	// Writable bits of the sequencer configuration
	localparam logic [15:0] SCFG_MASK = 16'hff13;
	// Field positions
	localparam int SRC_LSB   = 13;
	localparam int QEN_BIT   = 11;
	localparam int RUN_BIT   = 0;
	localparam int HALT_BIT  = 1;
	// Result source codes; all other codes select ADC words
	localparam logic [2:0] SRC_DFT   = 3'h2;
	localparam logic [2:0] SRC_SINC2 = 3'h3;
	localparam logic [2:0] SRC_VAR   = 3'h4;
	localparam logic [2:0] SRC_MEAN  = 3'h5;
	// Checksum polynomial x^8+x^2+x+1
	localparam logic [7:0]  CRC_POLY  = 8'h07;
	// Sleep unlock password
	localparam logic [19:0] SLEEP_PW  = 20'ha47e5;
	// Queue depths
	localparam int RQ_DEPTH = 8;
	localparam int CQ_DEPTH = 8;
endpackage

// [design/sfc_top.sv]
`timescale 1ns/10ps
// Notes on behaviour
// - ADC codes queue corrected sinc3 samples
// - Code 010 queues 18-bit real, imaginary pairs
// - Low two transform bits are fractional
// - Code 011 queues 16-bit sinc2 words
// - Code 100 queues 30-bit variance, two words
// - Code 101 queues 16-bit mean words
// - Queue disabled: flushed, empty, no transfers
// - Running CRC-8 over executed commands
// - Checksum read-only, resets to 0x01
// - Timeout counter readable, 30 bits
// - Reading empty result queue returns zero
// - Writes to full command queue dropped
// - Password 0xA47E5 unlocks sleep trigger
// - Any other lock value locks trigger
// - Run enable fetches commands, else idle
// - Halt on underflow when bit set

// Synchronous FIFO; depth must be a power of two
module sfc_fifo #(
	parameter int W = 32,
	parameter int D = 8
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic         clr,
	input  wire logic         inValid,
	input  wire logic [W-1:0] inData,
	output logic              inReady,
	output logic              outValid,
	output logic [W-1:0]      outData,
	input  wire logic         outReady,
	output logic [$clog2(D):0] count
);
	localparam int AW = $clog2(D);
	localparam int CW = AW + 1;

	// Whole FIFO state
	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [CW-1:0]       cnt;
	} sfc_fifo_st_t;

	sfc_fifo_st_t st_reg;  // Registered state
	sfc_fifo_st_t st_next; // Next state
	logic         push;    // Word accepted
	logic         pop;     // Word drained

	// Clear holds it empty and refuses both sides
	assign inReady  = !clr && (st_reg.cnt != CW'(D));
	assign outValid = !clr && (st_reg.cnt != '0);
	assign outData  = st_reg.mem[st_reg.rp];
	assign count    = st_reg.cnt;
	assign push     = inValid && inReady;
	assign pop      = outValid && outReady;

	// Pointer and count update
	always_comb begin
		st_next = st_reg;
		if (clr) begin
			st_next.wp  = '0;
			st_next.rp  = '0;
			st_next.cnt = '0;
		end else begin
			if (push) begin
				st_next.mem[st_reg.wp] = inData;
				st_next.wp = st_reg.wp + AW'(1);
			end
			if (pop) begin
				st_next.rp = st_reg.rp + AW'(1);
			end
			case ({push, pop})
				2'b10: st_next.cnt = st_reg.cnt + CW'(1);
				2'b01: st_next.cnt = st_reg.cnt - CW'(1);
				default: st_next.cnt = st_reg.cnt;
			endcase
		end
	end

	// State register
	always_ff @(posedge clk) begin
		if (rst) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end
endmodule

module sfc_top
	import sfc_pkg::*;
#(
	parameter int RQD = RQ_DEPTH,
	parameter int CQD = CQ_DEPTH
) (
	input  wire logic        sys_clk,
	input  wire logic        rst,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [13:0] wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	input  wire logic        adcValid,
	input  wire logic [15:0] adcData,
	input  wire logic        dftValid,
	input  wire logic [17:0] dftReal,
	input  wire logic [17:0] dftImag,
	input  wire logic        sinc2Valid,
	input  wire logic [15:0] sinc2Data,
	input  wire logic        varValid,
	input  wire logic [29:0] varData,
	input  wire logic        meanValid,
	input  wire logic [15:0] meanData,
	output logic             srcReady,
	output logic [31:0]      cmdWord,
	output logic             cmdValid,
	input  wire logic        cmdReady,
	output logic             seqRunning,
	output logic             sleepRequest
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Whole block state
	typedef struct packed {
		logic        ack;
		logic [31:0] rdat;
		logic [15:0] qcfg;
		logic [15:0] scfg;
		logic [7:0]  crc;
		logic [29:0] tmo;
		logic [19:0] lock;
		logic        trig;
		logic        pendValid;
		logic [31:0] pendWord;
	} sfc_state_t;

	sfc_state_t s_reg;       // Registered state
	sfc_state_t s_next;      // Next state
	logic        req;        // New bus request
	logic        wr;         // Write request
	logic        rd;         // Read request
	logic [31:0] mask;       // Byte lane mask
	logic [2:0]  src;        // Result source code
	logic        qEn;        // Result queue enabled
	logic        run;        // Sequencer running
	logic        selValid;   // Selected stream valid
	logic        twoWord;    // Source needs two words
	logic [31:0] firstWord;  // First queue word
	logic [31:0] secondWord; // Second queue word
	logic        rqInValid;  // Result queue push
	logic [31:0] rqInData;   // Result queue data
	logic        rqInReady;  // Result queue room
	logic        rqOutValid; // Result queue not empty
	logic [31:0] rqOutData;  // Oldest result word
	logic        rqPop;      // Read drains a word
	logic [$clog2(RQD):0] rqCount; // Result fill
	logic        cqInValid;  // Command write
	logic        cqInReady;  // Command queue room
	logic        cqOutValid; // Command waiting
	logic        cmdPop;     // Command executed
	logic        underflow;  // Fetch from empty
	logic [$clog2(CQD):0] cqCount; // Command fill

	// Bitwise CRC-8 over one word, MSB first
	function automatic logic [7:0] crc8(
		input logic [7:0]  c,
		input logic [31:0] d
	);
		logic [7:0] r;
		r = c;
		for (int i = 31; i >= 0; i--) begin
			r = {r[6:0], 1'b0} ^ ((r[7] ^ d[i]) ? CRC_POLY : 8'h00);
		end
		return r;
	endfunction

	// Bus decode; one request per ack
	assign req  = wb_cyc_i && wb_stb_i && !s_reg.ack;
	assign wr   = req && wb_we_i;
	assign rd   = req && !wb_we_i;
	assign mask = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
	assign src  = s_reg.qcfg[SRC_LSB +: 3];
	assign qEn  = s_reg.qcfg[QEN_BIT];
	assign run  = s_reg.scfg[RUN_BIT];

	// Source word shaping
	always_comb begin
		selValid   = adcValid;
		twoWord    = 1'b0;
		firstWord  = {16'h0000, adcData};
		secondWord = 32'h0000_0000;
		case (src)
			SRC_DFT: begin
				// Raw 18-bit parts; bits [1:0] are fraction
				selValid   = dftValid;
				twoWord    = 1'b1;
				firstWord  = {{14{dftReal[17]}}, dftReal};
				secondWord = {{14{dftImag[17]}}, dftImag};
			end
			SRC_SINC2: begin
				selValid  = sinc2Valid;
				firstWord = {16'h0000, sinc2Data};
			end
			SRC_VAR: begin
				// Low half first, then the top 14 bits
				selValid   = varValid;
				twoWord    = 1'b1;
				firstWord  = {16'h0000, varData[15:0]};
				secondWord = {18'h00000, varData[29:16]};
			end
			SRC_MEAN: begin
				selValid  = meanValid;
				firstWord = {16'h0000, meanData};
			end
			default: begin
				selValid = adcValid;
			end
		endcase
	end

	// Stall sources while a second half is pending
	assign srcReady  = qEn && rqInReady && !s_reg.pendValid;
	assign rqInValid = qEn && (s_reg.pendValid || selValid);
	assign rqInData  = s_reg.pendValid ? s_reg.pendWord : firstWord;
	assign rqPop     = rd && (wb_adr_i == RQOUT_OFS);

	sfc_fifo #(
		.W (32),
		.D (RQD)
	) u_result (
		.clk      (sys_clk),
		.rst      (rst),
		.clr      (!qEn),
		.inValid  (rqInValid),
		.inData   (rqInData),
		.inReady  (rqInReady),
		.outValid (rqOutValid),
		.outData  (rqOutData),
		.outReady (rqPop),
		.count    (rqCount)
	);

	// Full queue refuses the write, contents kept
	assign cqInValid = wr && (wb_adr_i == CQIN_OFS);
	assign cmdValid  = run && cqOutValid;
	assign cmdPop    = cmdValid && cmdReady;
	assign underflow = run && cmdReady && !cqOutValid;

	sfc_fifo #(
		.W (32),
		.D (CQD)
	) u_command (
		.clk      (sys_clk),
		.rst      (rst),
		.clr      (1'b0),
		.inValid  (cqInValid),
		.inData   (wb_dat_i),
		.inReady  (cqInReady),
		.outValid (cqOutValid),
		.outData  (cmdWord),
		.outReady (cmdPop),
		.count    (cqCount)
	);

	assign wb_ack_o     = s_reg.ack;
	assign wb_dat_o     = s_reg.rdat;
	assign seqRunning   = run;
	assign sleepRequest = s_reg.trig;

	// Next state of registers and sequencer
	always_comb begin
		s_next      = s_reg;
		s_next.ack  = req;
		s_next.rdat = 32'h0000_0000;
		// Second half of a pair goes in next
		if (!qEn) begin
			s_next.pendValid = 1'b0;
		end else if (s_reg.pendValid) begin
			s_next.pendValid = !rqInReady;
		end else if (selValid && srcReady && twoWord) begin
			s_next.pendValid = 1'b1;
			s_next.pendWord  = secondWord;
		end
		// Checksum follows every executed command
		if (cmdPop) begin
			s_next.crc = crc8(s_reg.crc, cmdWord);
		end
		// Timeout counts while running, saturates
		if (run && (s_reg.tmo != '1)) begin
			s_next.tmo = s_reg.tmo + 30'(1);
		end
		// Underflow stops the sequencer if asked to
		if (underflow && s_reg.scfg[HALT_BIT]) begin
			s_next.scfg[RUN_BIT] = 1'b0;
		end
		// Register writes land after hardware updates
		if (wr) begin
			case (wb_adr_i)
				SCFG_OFS: begin
					s_next.scfg = ((s_next.scfg & ~mask[15:0])
						| (wb_dat_i[15:0] & mask[15:0])) & SCFG_MASK;
				end
				QCFG_OFS: begin
					s_next.qcfg = (s_reg.qcfg & ~mask[15:0])
						| (wb_dat_i[15:0] & mask[15:0]);
				end
				LOCK_OFS: begin
					s_next.lock = (s_reg.lock & ~mask[19:0])
						| (wb_dat_i[19:0] & mask[19:0]);
				end
				TRIG_OFS: begin
					// Ignored unless the password stands
					if ((s_reg.lock == SLEEP_PW) && wb_sel_i[0]) begin
						s_next.trig = wb_dat_i[0];
					end
				end
				default: begin
					s_next.trig = s_next.trig;
				end
			endcase
		end
		// Read data; unmapped reads answer zero
		if (rd) begin
			case (wb_adr_i)
				SCFG_OFS:  s_next.rdat = {16'h0000, s_reg.scfg};
				QCFG_OFS:  s_next.rdat = {16'h0000, s_reg.qcfg};
				CRC_OFS:   s_next.rdat = {24'h000000, s_reg.crc};
				TMO_OFS:   s_next.rdat = {2'b00, s_reg.tmo};
				RQOUT_OFS: s_next.rdat = rqOutValid ? rqOutData
					: 32'h0000_0000;
				LOCK_OFS:  s_next.rdat = {12'h000, s_reg.lock};
				TRIG_OFS:  s_next.rdat = {31'h0, s_reg.trig};
				default:   s_next.rdat = 32'h0000_0000;
			endcase
		end
	end

	// State register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_reg      <= '0;
			s_reg.qcfg <= QCFG_RST;
			s_reg.scfg <= SCFG_RST;
			s_reg.crc  <= CRC_RST;
		end else begin
			s_reg <= s_next;
		end
	end

	// Bus handshake checks
	a_ack_follows: assert property (req |=> wb_ack_o)
		else $error("request not acked next cycle");
	a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held over two cycles");

	// Queue data checks
	a_empty_zero: assert property (
		(rd && wb_adr_i == RQOUT_OFS && !rqOutValid)
		|=> wb_dat_o == 32'h0000_0000)
		else $error("empty read not zero");
	a_read_pops: assert property (
		(rqPop && rqOutValid && !rqInValid && qEn)
		|=> rqCount == $past(rqCount) - 1'b1)
		else $error("read did not drain word");
	// Refusal is immediate; the clear lands one edge later
	a_disable_flush: assert property (
		!qEn |-> (!srcReady && !rqOutValid) ##1 (rqCount == '0))
		else $error("disabled queue not empty");
	// Second half may wait while the queue is full
	a_pair_second: assert property (
		(selValid && srcReady && twoWord) |=> s_reg.pendValid
		##1 (!s_reg.pendValid || !$past(rqInReady)))
		else $error("second half not queued");
	a_dft_imag: assert property (
		(src == SRC_DFT && dftValid && srcReady)
		|=> s_reg.pendWord[17:0] == $past(dftImag))
		else $error("imaginary part lost");
	a_adc_word: assert property (
		(rqInValid && !s_reg.pendValid && src == 3'h0)
		|-> rqInData == {16'h0000, adcData})
		else $error("ADC word malformed");

	// Command path checks
	a_full_drop: assert property (
		(cqInValid && !cqInReady && !cmdPop)
		|=> cqCount == $past(cqCount))
		else $error("full queue write changed count");
	a_idle_fetch: assert property (!run |-> !cmdValid)
		else $error("idle sequencer fetched");
	a_halt_stop: assert property (
		(underflow && s_reg.scfg[HALT_BIT]
		&& !(wr && wb_adr_i == SCFG_OFS)) |=> !run)
		else $error("underflow did not halt");
	a_crc_hold: assert property (!cmdPop |=> $stable(s_reg.crc))
		else $error("checksum moved without command");
	a_crc_reset: assert property (
		$past(rst) |-> s_reg.crc == CRC_RST)
		else $error("checksum reset value wrong");
	a_tmo_count: assert property (
		(run && s_reg.tmo != '1) |=> s_reg.tmo == $past(s_reg.tmo) + 1'b1)
		else $error("timeout counter stalled");
	a_lock_guard: assert property (
		(wr && wb_adr_i == TRIG_OFS && s_reg.lock != SLEEP_PW)
		|=> $stable(sleepRequest))
		else $error("locked trigger changed");
	a_unlock_set: assert property (
		(wr && wb_adr_i == TRIG_OFS && s_reg.lock == SLEEP_PW
		&& wb_sel_i[0]) |=> sleepRequest == $past(wb_dat_i[0]))
		else $error("unlocked trigger not written");

	// Main scenarios
	c_pair: cover property (src == SRC_VAR && varValid && srcReady
		##1 s_reg.pendValid ##1 !s_reg.pendValid);
	c_full: cover property (cqInValid && !cqInReady);
	c_halt: cover property (underflow && s_reg.scfg[HALT_BIT]);
	c_sleep: cover property (wr && wb_adr_i == TRIG_OFS
		&& s_reg.lock == SLEEP_PW ##1 sleepRequest);
endmodule

// [tb/sfc_cmd_sink.sv]
`timescale 1ns/10ps
// Command executor standing at the far side of the command port
module sfc_cmd_sink (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic        slow,
	input  wire logic        cmdValid,
	input  wire logic [31:0] cmdWord,
	output logic             cmdReady
);
	logic [1:0]  phase;  // Stall pattern counter
	logic [31:0] got[$]; // Words taken, oldest first
	// Ready every cycle, or one cycle in four when slow
	// Ready also stands while nothing is offered, as a polling
	// executor would, so an empty queue is really underflowed
	always @(posedge clk) begin
		phase <= rst ? 2'h0 : phase + 2'h1;
		cmdReady <= !rst && (!slow || phase == 2'h3);
		// Take only on a real handshake
		if (!rst && cmdValid && cmdReady)
			got.push_back(cmdWord);
	end
endmodule

// [tb/sequencer_fifo_control_test.sv]
`timescale 1ns/10ps
// Self-checking bench for the queue control block
module sequencer_fifo_control_test
	import sfc_pkg::*;
;
	logic        clk, rst, cyc, stb, we, slow;  // Bench drives
	logic [13:0] adr;                           // Bus address
	logic [31:0] wdat, rdat, v;                 // Bus data, last read
	logic        ack, srcReady, cmdValid, cmdReady, seqRun, sleepReq;
	logic [31:0] cmdWord;
	logic [4:0]  vld;                           // All source valids
	logic [35:0] r;                             // Shared source sample
	logic [31:0] q[$];                          // Expected result words
	logic [31:0] cw[9];                         // Commands written
	logic [7:0]  e;                             // Expected checksum
	int          n_fail, checks, tick;
	localparam logic [13:0] RA[6] = '{QCFG_OFS, CRC_OFS, TMO_OFS,
		RQOUT_OFS, LOCK_OFS, 14'h2100};
	localparam logic [31:0] RV[6] = '{32'h1010, 32'h1, 32'h0, 32'h0,
		32'h0, 32'h0};

	sfc_top sfc_top_inst (.sys_clk(clk), .rst(rst), .wb_cyc_i(cyc),
		.wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.adcValid(vld[0]), .adcData(r[15:0]), .dftValid(vld[1]),
		.dftReal(r[17:0]), .dftImag(r[35:18]), .sinc2Valid(vld[2]),
		.sinc2Data(r[31:16]), .varValid(vld[3]), .varData(r[29:0]),
		.meanValid(vld[4]), .meanData(r[23:8]), .srcReady(srcReady),
		.cmdWord(cmdWord), .cmdValid(cmdValid), .cmdReady(cmdReady),
		.seqRunning(seqRun), .sleepRequest(sleepReq));

	sfc_cmd_sink sfc_cmd_sink_inst (.clk(clk), .rst(rst), .slow(slow),
		.cmdValid(cmdValid), .cmdWord(cmdWord), .cmdReady(cmdReady));

	// Expected queue word for a source code and sample
	function automatic logic [31:0] fmtw(logic [2:0] c, logic [35:0] s,
		bit hi);
		case (c)
			SRC_DFT: return hi ? {{14{s[35]}}, s[35:18]}
				: {{14{s[17]}}, s[17:0]};
			SRC_SINC2: return {16'h0, s[31:16]};
			SRC_VAR: return hi ? {18'h0, s[29:16]} : {16'h0, s[15:0]};
			SRC_MEAN: return {16'h0, s[23:8]};
			default: return {16'h0, s[15:0]};
		endcase
	endfunction

	// Checksum step, MSB first over one command
	function automatic logic [7:0] crc8(logic [7:0] c, logic [31:0] d);
		for (int i = 31; i >= 0; i--)
			c = {c[6:0], 1'h0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
		return c;
	endfunction

	// Compare and count
	task automatic chk(input logic [31:0] s, input logic [31:0] x);
		checks++;
		if (s !== x) begin
			n_fail++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, x);
		end
	endtask

	// One classic cycle; held until ack, then one idle cycle
	// No local limit: only the hang guard ends a wait
	task automatic bus(input logic [13:0] a, input logic w,
		input logic [31:0] d);
		cyc <= 1'h1;
		stb <= 1'h1;
		we <= w;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
		end while (ack !== 1'h1);
		v = rdat;
		cyc <= 1'h0;
		stb <= 1'h0;
		we <= 1'h0;
		@(posedge clk);
	endtask

	// One sample; every valid up, so only the selected source counts
	task automatic send(input logic [2:0] c);
		logic [35:0] s;
		s = {4'($urandom), 32'($urandom)};
		r <= s;
		vld <= 5'h1f;
		do begin
			@(posedge clk);
		end while (srcReady !== 1'h1);
		vld <= 5'h00;
		q.push_back(fmtw(c, s, 1'b0));
		if (c == SRC_DFT || c == SRC_VAR)
			q.push_back(fmtw(c, s, 1'b1));
		@(posedge clk);
	endtask

	// Verdict and end of run
	task automatic wrap_up();
		if (n_fail == 0 && checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// Clock
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end

	// Hang guard, well above the few hundred cycles needed
	always @(posedge clk) begin
		tick++;
		if (tick == 8000) begin
			n_fail++;
			wrap_up();
		end
	end

	// Main sequence
	initial begin
		rst = 1'h1;
		{cyc, stb, we, adr, wdat, vld, r} = '0;
		slow = 1'h1;
		void'($urandom(98449));
		repeat (4) @(posedge clk);
		rst <= 1'h0;
		// Reset values, an unmapped place among them
		foreach (RA[i]) begin
			bus(RA[i], 1'h0, 32'h0);
			chk(v, RV[i]);
		end
		bus(CRC_OFS, 1'h1, 32'hff);
		// Every source code: fill until refused, then drain
		for (int c = 0; c < 8; c++) begin
			bus(QCFG_OFS, 1'h1, {16'hffff, 3'(c), 13'h1810});
			bus(QCFG_OFS, 1'h0, 32'h0);
			chk(v, {16'h0, 3'(c), 13'h1810});
			repeat ((c == 2 || c == 4) ? 4 : 8) send(3'(c));
			chk({31'h0, srcReady}, 32'h0);
			repeat (8) begin
				bus(RQOUT_OFS, 1'h0, 32'h0);
				chk(v, q.pop_front());
			end
			bus(RQOUT_OFS, 1'h0, 32'h0);
			chk(v, 32'h0);
		end
		// Disabling flushes the queue
		send(3'h7);
		send(3'h7);
		bus(QCFG_OFS, 1'h1, 32'h1010);
		chk({31'h0, srcReady}, 32'h0);
		bus(QCFG_OFS, 1'h1, 32'h1810);
		bus(RQOUT_OFS, 1'h0, 32'h0);
		chk(v, 32'h0);
		// Nine commands into eight places while idle
		for (int i = 0; i < 9; i++) begin
			cw[i] = $urandom;
			bus(CQIN_OFS, 1'h1, cw[i]);
		end
		chk({31'h0, cmdValid}, 32'h0);
		bus(SCFG_OFS, 1'h1, 32'h3);
		for (int i = 0; i < 300 && seqRun !== 1'h0; i++)
			@(posedge clk);
		chk(sfc_cmd_sink_inst.got.size(), 32'h8);
		e = CRC_RST;
		for (int i = 0; i < 8; i++) begin
			chk(sfc_cmd_sink_inst.got[i], cw[i]);
			e = crc8(e, cw[i]);
		end
		bus(CRC_OFS, 1'h0, 32'h0);
		chk(v, {24'h0, e});
		bus(SCFG_OFS, 1'h0, 32'h0);
		chk(v, 32'h2);
		bus(TMO_OFS, 1'h0, 32'h0);
		chk(32'(v != 32'h0 && v[31:30] == 2'h0), 32'h1);
		// Halt bit clear: keeps retrying on an empty queue
		slow <= 1'h0;
		bus(SCFG_OFS, 1'h1, 32'h1);
		repeat (20) @(posedge clk);
		chk({31'h0, seqRun}, 32'h1);
		bus(SCFG_OFS, 1'h1, 32'h0);
		chk({31'h0, seqRun}, 32'h0);
		// Sleep trigger behind the password
		bus(TRIG_OFS, 1'h1, 32'h1);
		chk({31'h0, sleepReq}, 32'h0);
		bus(LOCK_OFS, 1'h1, {12'h0, SLEEP_PW});
		bus(LOCK_OFS, 1'h0, 32'h0);
		chk(v, {12'h0, SLEEP_PW});
		bus(TRIG_OFS, 1'h1, 32'h1);
		chk({31'h0, sleepReq}, 32'h1);
		bus(LOCK_OFS, 1'h1, 32'ha47e4);
		bus(TRIG_OFS, 1'h1, 32'h0);
		chk({31'h0, sleepReq}, 32'h1);
		wrap_up();
	end
endmodule
